// *** design/lmi_pkg.sv ***
/*
 * Shared constants for the LED matrix intensity block: register offsets,
 * field positions, reset values, frame modulation patterns and PWM sizes.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package lmi_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PANEL_BRIGHTNESS_ADDR      = 8'h02;
	localparam logic [7:0] DIGIT_ZERO_BRIGHTNESS_ADDR = 8'h03;
	localparam logic [7:0] DIGIT_ONE_BRIGHTNESS_ADDR  = 8'h04;
	localparam logic [7:0] PANEL_CONFIGURATION_ADDR   = 8'h0D;

	// ----------------------------------------------------------------
	// panel configuration fields
	// ----------------------------------------------------------------
	localparam int CFG_SHUTDOWN_BIT     = 0;
	localparam int CFG_POLARITY_BIT     = 1;
	localparam int CFG_PLANE_LO_BIT     = 2;
	localparam int CFG_PLANE_HI_BIT     = 3;
	localparam int CFG_RIPPLE_BIT       = 4;
	localparam int CFG_FLIP_BIT         = 5;
	localparam int CFG_COLOUR_BIT       = 6;
	localparam int CFG_PLANE_DEPTH_BIT  = 7;

	// ----------------------------------------------------------------
	// reset values and the unmapped read value
	// ----------------------------------------------------------------
	localparam logic [7:0] PANEL_BRIGHTNESS_RESET = 8'hFF;
	localparam logic [7:0] DIGIT_BRIGHTNESS_RESET = 8'hFF;
	localparam logic [7:0] PANEL_CONFIG_RESET     = 8'h00;
	localparam logic [7:0] READ_DATA_RESET        = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;

	// ----------------------------------------------------------------
	// panel modulator
	// ----------------------------------------------------------------
	localparam int         PWM_WIDTH          = 8;
	localparam logic [7:0] PANEL_MIN_CODE     = 8'h03;
	localparam logic [7:0] PANEL_MIN_DUTY     = 8'h02;

	// ----------------------------------------------------------------
	// frame modulation, bit i is frame index i
	// ----------------------------------------------------------------
	localparam int          FRAME_CYCLE_LEN  = 12;
	localparam logic [3:0]  FRAME_INDEX_LAST = 4'hB;
	localparam logic [11:0] PATTERN_FULL     = 12'hFFF;
	localparam logic [11:0] PATTERN_ARITH_HI = 12'hB6D;
	localparam logic [11:0] PATTERN_ARITH_LO = 12'h492;
	localparam logic [11:0] PATTERN_GEOM_HI  = 12'h555;
	localparam logic [11:0] PATTERN_GEOM_LO  = 12'h222;
	localparam logic [11:0] PATTERN_OFF      = 12'h000;

	// ----------------------------------------------------------------
	// plane limits
	// ----------------------------------------------------------------
	localparam logic [1:0] PLANE_LAST_ONE_BIT = 2'h3;
	localparam logic [1:0] PLANE_LAST_TWO_BIT = 2'h1;

endpackage

// *** design/lmi_frame_pattern.sv ***
/*
 * Frame modulation decoder for one digit: turns a pixel code, the pixel
 * depth mode, the graduation type and the frame index into a lit flag.
 * Assumes the frame index stays within 0 to 11.
 */
`timescale 1ns/100ps
module lmi_frame_pattern (
	// pixel
	input  wire logic [1:0] pix_code,
	input  wire logic       two_bit,
	input  wire logic       geometric,
	// frame position
	input  wire logic [3:0] frame_index,
	// result
	output logic            lit
);

	logic [11:0] pattern;

	always_comb begin
		pattern = lmi_pkg::PATTERN_OFF;
		if (!two_bit) begin
			// single bit per pixel: on or off for every frame
			pattern = pix_code[0] ? lmi_pkg::PATTERN_FULL : lmi_pkg::PATTERN_OFF; // see (RL19)
		end else begin
			unique case (pix_code) // see (RL6)
				2'b11: pattern = lmi_pkg::PATTERN_FULL; // see (RL7)
				2'b10: pattern = geometric ? lmi_pkg::PATTERN_GEOM_HI
				                           : lmi_pkg::PATTERN_ARITH_HI; // see (RL7)
				2'b01: pattern = geometric ? lmi_pkg::PATTERN_GEOM_LO
				                           : lmi_pkg::PATTERN_ARITH_LO; // see (RL7)
				2'b00: pattern = lmi_pkg::PATTERN_OFF; // see (RL7)
			endcase
		end
		lit = pattern[frame_index];
	end

endmodule

// *** design/lmi_digit_pwm.sv ***
/*
 * Per-digit PWM stage: scales the panel duty by the digit code in n/256
 * steps and compares it with the shared PWM counter.
 * Assumes the PWM counter runs 0 to 255 and wraps.
 */
`timescale 1ns/100ps
module lmi_digit_pwm #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// duty sources
	input  wire logic [WIDTH-1:0] pwm_count,
	input  wire logic [WIDTH-1:0] panel_duty,
	input  wire logic [WIDTH-1:0] digit_code,
	input  wire logic             pixel_lit,
	// drive
	output logic                  drive
);

	logic [2*WIDTH-1:0] product;
	logic [WIDTH-1:0]   threshold;
	logic [WIDTH-1:0]   next_threshold;
	logic               next_drive;

	initial begin
		if (WIDTH < 2)
			$error("lmi_digit_pwm: WIDTH must be at least 2");
	end

	always_comb begin
		// upper byte of the product gives n/256 of the panel duty
		product        = panel_duty * digit_code; // see (RL9)
		next_threshold = product[2*WIDTH-1:WIDTH]; // see (RL14)
		next_drive     = pixel_lit && (pwm_count < threshold);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			threshold <= '0;
			drive     <= 1'b0;
		end else begin
			threshold <= next_threshold;
			drive     <= next_drive;
		end
	end

endmodule

// *** design/lmi_intensity_top.sv ***
/*
 * Brightness and colour control for a two-digit 8x8 LED matrix driver:
 * panel configuration, panel and digit intensity registers, panel PWM,
 * per-digit PWM and frame-modulated pixel intensity.
 * Assumes a serial front end that turns host transfers into one-cycle
 * register write and read strobes, a plane sequencer that reports the
 * current plane, and display memory that presents the current pixel
 * codes of both digits in step with the PWM counter.
 */
// Notes on behaviour
// (RL1) colour bit 0: monocolour or RGB digits
// (RL2) colour bit 1: both digits form one RGY
// (RL3) depth bit 0: four planes, one bit
// (RL4) depth bit 1: two planes, two bits
// (RL5) reduced build fixes either bit at zero
// (RL6) codes map to arithmetic or geometric levels
// (RL7) partial levels by twelve-frame modulation patterns
// (RL8) graduation type chosen per digit
// (RL9) digit duty is n/256 of panel duty
// (RL10) digit zero intensity at 0x03
// (RL11) digit one intensity at 0x04
// (RL12) panel modulator spans 2/256 to 255/256
// (RL13) panel intensity at 0x02, codes map duty
// (RL14) highest digit duty is 254/256
// (RL15) current plane bits read only
// (RL16) writes to fixed bits ignored
// (RL17) graduation applies only in two-bit mode
// (RL18) free-running frame index advances each frame
// (RL19) one-bit mode: set bit lit full duty
`timescale 1ns/100ps
module lmi_intensity_top #(
	parameter bit HAS_COLOUR      = 1'b1,
	parameter bit HAS_PLANE_DEPTH = 1'b1,
	parameter int FRAME_PERIODS   = 16
) (
	// clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	// register access from the serial front end
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	// plane sequencer and graduation selection
	input  wire logic [1:0] CURRENT_PLANE,
	input  wire logic       DIGIT0_GEOMETRIC,
	input  wire logic       DIGIT1_GEOMETRIC,
	// current pixel codes from display memory
	input  wire logic [1:0] DIGIT0_PIXEL,
	input  wire logic [1:0] DIGIT1_PIXEL,
	// mode flags
	output logic            COLOUR_RGY,
	output logic            PIXEL_TWO_BIT,
	output logic      [1:0] PLANE_LAST,
	output logic            SHUTDOWN,
	// drive and timing
	output logic            PANEL_PWM,
	output logic            DIGIT0_DRIVE,
	output logic            DIGIT1_DRIVE,
	output logic            FRAME_START,
	output logic      [3:0] FRAME_INDEX
);

	localparam int W = lmi_pkg::PWM_WIDTH;

	// elaboration checks on the build options
	initial begin
		if (FRAME_PERIODS < 1 || FRAME_PERIODS > 65535)
			$error("lmi_intensity_top: FRAME_PERIODS out of range");
		// the registers are bytes, so the modulator must be a byte as well
		if (W != 8)
			$error("lmi_intensity_top: PWM_WIDTH must be 8");
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------

	// codes below the minimum all give the smallest duty,
	// so that a stray low code never blanks the panel
	function automatic logic [W-1:0] panel_duty_of(input logic [W-1:0] code);
		logic [W-1:0] duty;
		duty = code;
		if (code < lmi_pkg::PANEL_MIN_CODE)
			duty = lmi_pkg::PANEL_MIN_DUTY; // see (RL13)
		return duty;
	endfunction

	// one compare shared by every write decode; the read decode uses its own case on REG_ADDR
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	// ----------------------------------------------------------------
	// configuration write mask
	// ----------------------------------------------------------------
	logic [7:0] writable_mask;

	always_comb begin
		// plane bits never store; fixed variant bits are masked off
		writable_mask                          = 8'hFF;
		writable_mask[lmi_pkg::CFG_PLANE_LO_BIT] = 1'b0; // see (RL15)
		writable_mask[lmi_pkg::CFG_PLANE_HI_BIT] = 1'b0; // see (RL15)
		writable_mask[lmi_pkg::CFG_COLOUR_BIT]   = HAS_COLOUR; // see (RL5) (RL16)
		writable_mask[lmi_pkg::CFG_PLANE_DEPTH_BIT] = HAS_PLANE_DEPTH; // see (RL5) (RL16)
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] panel_brightness;
	logic [7:0] digit_zero_brightness;
	logic [7:0] digit_one_brightness;
	logic [7:0] config_stored;
	logic [7:0] next_panel_brightness;
	logic [7:0] next_digit_zero_brightness;
	logic [7:0] next_digit_one_brightness;
	logic [7:0] next_config_stored;
	logic [7:0] config_view;

	always_comb begin
		next_panel_brightness      = panel_brightness;
		next_digit_zero_brightness = digit_zero_brightness;
		next_digit_one_brightness  = digit_one_brightness;
		next_config_stored         = config_stored;
		if (REG_WR) begin
			if (hits(REG_ADDR, lmi_pkg::PANEL_BRIGHTNESS_ADDR))
				next_panel_brightness = REG_WDATA; // see (RL13)
			if (hits(REG_ADDR, lmi_pkg::DIGIT_ZERO_BRIGHTNESS_ADDR))
				next_digit_zero_brightness = REG_WDATA; // see (RL10)
			if (hits(REG_ADDR, lmi_pkg::DIGIT_ONE_BRIGHTNESS_ADDR))
				next_digit_one_brightness = REG_WDATA; // see (RL11)
			if (hits(REG_ADDR, lmi_pkg::PANEL_CONFIGURATION_ADDR))
				next_config_stored = REG_WDATA & writable_mask; // see (RL16)
		end

		// the read view shows the live plane in place of stored bits
		config_view = config_stored;
		config_view[lmi_pkg::CFG_PLANE_LO_BIT] = CURRENT_PLANE[0]; // see (RL15)
		config_view[lmi_pkg::CFG_PLANE_HI_BIT] = CURRENT_PLANE[1]; // see (RL15)
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			panel_brightness      <= lmi_pkg::PANEL_BRIGHTNESS_RESET;
			digit_zero_brightness <= lmi_pkg::DIGIT_BRIGHTNESS_RESET;
			digit_one_brightness  <= lmi_pkg::DIGIT_BRIGHTNESS_RESET;
			config_stored         <= lmi_pkg::PANEL_CONFIG_RESET;
		end else begin
			panel_brightness      <= next_panel_brightness;
			digit_zero_brightness <= next_digit_zero_brightness;
			digit_one_brightness  <= next_digit_one_brightness;
			config_stored         <= next_config_stored;
		end
	end

	// ----------------------------------------------------------------
	// read port and mode flags
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;
	logic       next_colour_rgy;
	logic       next_two_bit;
	logic [1:0] next_plane_last;
	logic       next_shutdown;

	always_comb begin
		next_rdata = REG_RDATA;
		// a read beside a write to the same register returns the old value
		if (REG_RD) begin
			unique case (REG_ADDR)
				lmi_pkg::PANEL_BRIGHTNESS_ADDR:      next_rdata = panel_brightness;
				lmi_pkg::DIGIT_ZERO_BRIGHTNESS_ADDR: next_rdata = digit_zero_brightness;
				lmi_pkg::DIGIT_ONE_BRIGHTNESS_ADDR:  next_rdata = digit_one_brightness;
				lmi_pkg::PANEL_CONFIGURATION_ADDR:   next_rdata = config_view;
				default:                             next_rdata = lmi_pkg::UNMAPPED_READ_VALUE;
			endcase
		end
		// colour 0: independent digits, colour 1: one red-green matrix
		// the flag is only reported; joint colour mapping lies outside this block
		next_colour_rgy = config_stored[lmi_pkg::CFG_COLOUR_BIT]; // see (RL1) (RL2)
		next_two_bit    = config_stored[lmi_pkg::CFG_PLANE_DEPTH_BIT]; // see (RL3) (RL4)
		next_plane_last = next_two_bit ? lmi_pkg::PLANE_LAST_TWO_BIT
		                               : lmi_pkg::PLANE_LAST_ONE_BIT; // see (RL3) (RL4)
		next_shutdown   = config_stored[lmi_pkg::CFG_SHUTDOWN_BIT];
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			REG_RDATA     <= lmi_pkg::READ_DATA_RESET;
			COLOUR_RGY    <= 1'b0;
			PIXEL_TWO_BIT <= 1'b0;
			PLANE_LAST    <= lmi_pkg::PLANE_LAST_ONE_BIT;
			SHUTDOWN      <= 1'b0;
		end else begin
			REG_RDATA     <= next_rdata;
			COLOUR_RGY    <= next_colour_rgy;
			PIXEL_TWO_BIT <= next_two_bit;
			PLANE_LAST    <= next_plane_last;
			SHUTDOWN      <= next_shutdown;
		end
	end

	// ----------------------------------------------------------------
	// panel PWM counter and frame index
	// ----------------------------------------------------------------
	logic [W-1:0] pwm_count;
	// sixteen bits hold the longest frame that the check above admits
	logic [15:0]  period_count;
	logic [3:0]   frame_index;
	logic [W-1:0] next_pwm_count;
	logic [15:0]  next_period_count;
	logic [3:0]   next_frame_index;
	logic         next_frame_start;
	logic         next_panel_pwm;
	logic         period_end;
	logic         frame_end;

	always_comb begin
		period_end        = (pwm_count == {W{1'b1}});
		frame_end         = period_end && (period_count == 16'(FRAME_PERIODS - 1));
		next_pwm_count    = pwm_count + 1'b1;
		next_period_count = period_count;
		next_frame_index  = frame_index;
		if (period_end)
			next_period_count = frame_end ? 16'h0000 : period_count + 16'h0001;
		if (frame_end) begin
			// twelve-entry cycle wraps back to zero
			// a longer frame slows the patterns but leaves the duty unchanged
			if (frame_index == lmi_pkg::FRAME_INDEX_LAST)
				next_frame_index = 4'h0; // see (RL18)
			else
				next_frame_index = frame_index + 4'h1; // see (RL18)
		end
		next_frame_start = frame_end;
		// compare against the shared counter; duty never reaches 256/256
		next_panel_pwm   = pwm_count < panel_duty_of(panel_brightness); // see (RL12)
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			pwm_count    <= '0;
			period_count <= 16'h0000;
			frame_index  <= 4'h0;
			FRAME_START  <= 1'b0;
			PANEL_PWM    <= 1'b0;
		end else begin
			pwm_count    <= next_pwm_count;
			period_count <= next_period_count;
			frame_index  <= next_frame_index;
			FRAME_START  <= next_frame_start;
			PANEL_PWM    <= next_panel_pwm;
		end
	end

	assign FRAME_INDEX = frame_index;

	// ----------------------------------------------------------------
	// per-digit modulation and drive
	// ----------------------------------------------------------------
	logic [1:0]   pix_code  [2];
	logic [1:0]   geometric;
	logic [W-1:0] digit_code [2];
	logic [1:0]   lit;
	logic [1:0]   drive;

	always_comb begin
		pix_code[0]   = DIGIT0_PIXEL;
		pix_code[1]   = DIGIT1_PIXEL;
		// each digit carries its own scale selection
		geometric     = {DIGIT1_GEOMETRIC, DIGIT0_GEOMETRIC}; // see (RL8)
		digit_code[0] = digit_zero_brightness;
		digit_code[1] = digit_one_brightness;
	end

	// pixel codes arrive in step with the counter, so the lit flag needs no register
	for (genvar d = 0; d < 2; d++) begin : g_digit
		lmi_frame_pattern u_pattern (
			.pix_code    (pix_code[d]),
			.two_bit     (config_stored[lmi_pkg::CFG_PLANE_DEPTH_BIT]), // see (RL17)
			.geometric   (geometric[d]),
			.frame_index (frame_index),
			.lit         (lit[d])
		);

		lmi_digit_pwm #(
			.WIDTH (W)
		) u_pwm (
			.clk        (CORE_CLK),
			.rst_n      (RST_N),
			.pwm_count  (pwm_count),
			.panel_duty (panel_duty_of(panel_brightness)),
			.digit_code (digit_code[d]),
			.pixel_lit  (lit[d]),
			.drive      (drive[d])
		);
	end

	// ----------------------------------------------------------------
	// digit outputs, straight from the stage flip-flops
	// ----------------------------------------------------------------
	assign DIGIT0_DRIVE = drive[0];
	assign DIGIT1_DRIVE = drive[1];

endmodule

// *** tb/lmi_host_model.sv ***
/*
 * Host side of the register port: one-cycle write and read strobes.
 * Assumes the bench calls its tasks from a single process.
 */
`timescale 1ns/100ps
module lmi_host_model (
	// clock
	input  wire logic       clk,
	// register strobes
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// released data must not look like a held value
		wdata <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
endmodule

// *** tb/lmi_intensity_properties.sv ***
/*
 * Checker for the intensity block, watching only its top ports.
 * Assumes it is bound with the build options of the block it watches.
 */
`timescale 1ns/100ps
module lmi_intensity_properties #(
	parameter int FRAME_PERIODS   = 16,
	parameter bit HAS_COLOUR      = 1'b1,
	parameter bit HAS_PLANE_DEPTH = 1'b1
) (
	// clock and reset
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	// sources
	input wire logic [1:0] CURRENT_PLANE,
	input wire logic       DIGIT0_GEOMETRIC,
	input wire logic       DIGIT1_GEOMETRIC,
	input wire logic [1:0] DIGIT0_PIXEL,
	input wire logic [1:0] DIGIT1_PIXEL,
	// outputs
	input wire logic       COLOUR_RGY,
	input wire logic       PIXEL_TWO_BIT,
	input wire logic [1:0] PLANE_LAST,
	input wire logic       SHUTDOWN,
	input wire logic       PANEL_PWM,
	input wire logic       DIGIT0_DRIVE,
	input wire logic       DIGIT1_DRIVE,
	input wire logic       FRAME_START,
	input wire logic [3:0] FRAME_INDEX
);
	localparam logic [19:0] FRAME_LEN = 20'(256 * FRAME_PERIODS - 1);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	// ----
	// shadow of the panel modulator
	// ----
	logic [7:0]  cnt;
	logic [7:0]  panel;
	logic        pwm_exp;
	logic [19:0] fcnt;
	logic        seen;
	logic [7:0]  duty;

	assign duty = (panel < 8'h03) ? 8'h02 : panel;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			cnt <= 8'h00;
			panel <= 8'hFF;
			pwm_exp <= 1'b0;
			fcnt <= 20'h00000;
			seen <= 1'b0;
		end else begin
			cnt <= cnt + 8'h01;
			if (REG_WR && REG_ADDR == 8'h02) begin
				panel <= REG_WDATA;
			end
			pwm_exp <= cnt < duty;
			fcnt <= FRAME_START ? 20'h00000 : fcnt + 20'h00001;
			seen <= seen | FRAME_START;
		end
	end

	// ----
	// properties
	// ----
	sequence s_cfg_wr;
		REG_WR && REG_ADDR == 8'h0D;
	endsequence
	sequence s_cfg_rd;
		REG_RD && REG_ADDR == 8'h0D;
	endsequence

	property p_colour;
		s_cfg_wr |=> ##1 COLOUR_RGY == (HAS_COLOUR & $past(REG_WDATA[6], 2));
	endproperty
	property p_depth;
		s_cfg_wr |=> ##1 PIXEL_TWO_BIT == (HAS_PLANE_DEPTH & $past(REG_WDATA[7], 2));
	endproperty
	property p_plane_last;
		s_cfg_wr |=> ##1
			PLANE_LAST == ((HAS_PLANE_DEPTH & $past(REG_WDATA[7], 2)) ? 2'h1 : 2'h3);
	endproperty
	property p_plane_read;
		s_cfg_rd |=> REG_RDATA[3:2] == $past(CURRENT_PLANE);
	endproperty
	property p_unmapped;
		REG_RD && !(REG_ADDR inside {8'h02, 8'h03, 8'h04, 8'h0D}) |=> REG_RDATA == 8'h00;
	endproperty
	property p_panel_read;
		REG_RD && REG_ADDR == 8'h02 |=> REG_RDATA == $past(panel);
	endproperty
	property p_pwm;
		PANEL_PWM == pwm_exp;
	endproperty
	property p_frame_step;
		FRAME_START |-> FRAME_INDEX ==
			(($past(FRAME_INDEX) == 4'hB) ? 4'h0 : $past(FRAME_INDEX) + 4'h1);
	endproperty
	property p_frame_hold;
		!FRAME_START && $past(RST_N) |-> $stable(FRAME_INDEX);
	endproperty
	property p_frame_range;
		FRAME_INDEX <= 4'hB;
	endproperty
	property p_frame_period;
		FRAME_START && seen |-> fcnt == FRAME_LEN;
	endproperty

	a_colour: assert property (p_colour) else $error("colour flag wrong");
	a_depth: assert property (p_depth) else $error("depth flag wrong");
	a_plane_last: assert property (p_plane_last) else $error("plane limit wrong");
	a_plane_read: assert property (p_plane_read) else $error("plane bits wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_panel_read: assert property (p_panel_read) else $error("panel read wrong");
	a_pwm: assert property (p_pwm) else $error("panel pwm wrong");
	a_frame_step: assert property (p_frame_step) else $error("index step wrong");
	a_frame_hold: assert property (p_frame_hold) else $error("index moved");
	a_frame_range: assert property (p_frame_range) else $error("index range");
	a_frame_period: assert property (p_frame_period) else $error("frame length");
endmodule

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the full and a reduced intensity block with a host model.
 * Assumes a one-period frame so twelve frames stay short.
 */
`timescale 1ns/100ps
module tb_top;
	localparam int FP = 1;
	logic       clk;
	logic       rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       wr;
	logic       rd;
	logic [1:0] plane;
	logic [1:0] pix0;
	logic [1:0] pix1;
	logic       geo0;
	logic       geo1;
	logic       rgy;
	logic       two_bit;
	logic [1:0] last;
	logic       pwm;
	logic       drv0;
	logic       drv1;
	logic       start;
	logic [3:0] fidx;
	logic       shut;
	logic [7:0] rdata_min;
	logic       rgy_min;
	logic       two_min;
	logic [7:0] rv;
	int         mismatches;
	int         tests_run;
	logic [7:0] tp [5] = '{8'hFF, 8'h01, 8'h02, 8'h03, 8'h80};
	logic [7:0] t0 [5] = '{8'hFF, 8'h80, 8'hFF, 8'h40, 8'h80};
	logic [7:0] t1 [5] = '{8'hFF, 8'h00, 8'h01, 8'hC0, 8'hFF};

	lmi_host_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));

	lmi_intensity_top #(.FRAME_PERIODS(FP)) u_dut (
		.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CURRENT_PLANE(plane),
		.DIGIT0_GEOMETRIC(geo0), .DIGIT1_GEOMETRIC(geo1), .DIGIT0_PIXEL(pix0),
		.DIGIT1_PIXEL(pix1), .COLOUR_RGY(rgy), .PIXEL_TWO_BIT(two_bit),
		.PLANE_LAST(last), .SHUTDOWN(shut), .PANEL_PWM(pwm), .DIGIT0_DRIVE(drv0),
		.DIGIT1_DRIVE(drv1), .FRAME_START(start), .FRAME_INDEX(fidx));

	// reduced build with both optional configuration bits fixed at zero
	lmi_intensity_top #(.HAS_COLOUR(1'b0), .HAS_PLANE_DEPTH(1'b0), .FRAME_PERIODS(FP))
	u_dut_min (
		.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata_min), .CURRENT_PLANE(plane),
		.DIGIT0_GEOMETRIC(geo0), .DIGIT1_GEOMETRIC(geo1), .DIGIT0_PIXEL(pix0),
		.DIGIT1_PIXEL(pix1), .COLOUR_RGY(rgy_min), .PIXEL_TWO_BIT(two_min),
		.PLANE_LAST(), .SHUTDOWN(), .PANEL_PWM(), .DIGIT0_DRIVE(), .DIGIT1_DRIVE(),
		.FRAME_START(), .FRAME_INDEX());

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		u_host.read_reg(a, rv);
		check("rdata", {4'h0, rv}, {4'h0, e});
	endtask

	// counts high cycles over one whole modulator period
	task automatic duty(input logic [7:0] p, input logic [7:0] n0, input logic [7:0] n1);
		logic [11:0] cp;
		logic [11:0] c0;
		logic [11:0] c1;
		logic [15:0] d;
		u_host.write_reg(8'h02, p);
		u_host.write_reg(8'h03, n0);
		u_host.write_reg(8'h04, n1);
		rd_chk(8'h02, p);
		rd_chk(8'h03, n0);
		rd_chk(8'h04, n1);
		repeat (4) @(posedge clk);
		cp = 12'h000;
		c0 = 12'h000;
		c1 = 12'h000;
		repeat (256) begin
			@(posedge clk);
			#1;
			cp = cp + {11'h000, pwm};
			c0 = c0 + {11'h000, drv0};
			c1 = c1 + {11'h000, drv1};
		end
		d = (p < 8'h03) ? 16'h0002 : {8'h00, p};
		check("panel", cp, d[11:0]);
		check("digit0", c0, 12'((d * {8'h00, n0}) >> 8));
		check("digit1", c1, 12'((d * {8'h00, n1}) >> 8));
	endtask

	// records per frame index whether each digit was lit at all
	task automatic frames(input logic [11:0] e0, input logic [11:0] e1);
		logic [11:0] s0;
		logic [11:0] s1;
		logic [3:0]  i;
		s0 = 12'h000;
		s1 = 12'h000;
		@(posedge start);
		repeat (12) begin
			@(posedge start);
			#1 i = fidx;
			repeat (8) @(posedge clk);
			repeat (190) begin
				@(posedge clk);
				#1;
				s0[i] = s0[i] | drv0;
				s1[i] = s1[i] | drv1;
			end
		end
		check("frames0", s0, e0);
		check("frames1", s1, e1);
	endtask

	task automatic give_verdict;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		give_verdict();
	end

	initial begin
		mismatches = 0;
		tests_run = 0;
		rst_n = 1'b0;
		plane = 2'h2;
		pix0 = 2'h3;
		pix1 = 2'h3;
		geo0 = 1'b0;
		geo1 = 1'b1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(8'h02, 8'hFF);
		rd_chk(8'h0D, 8'h08);
		u_host.write_reg(8'h05, 8'hAA);
		rd_chk(8'h05, 8'h00);
		$display("test reset done");
		u_host.write_reg(8'h0D, 8'hFF);
		rd_chk(8'h0D, 8'hFB);
		check("reduced", {2'h0, rgy_min, two_min, rdata_min}, 12'h03B);
		check("modes", {6'h00, shut, rgy, two_bit, 1'b0, last}, 12'h039);
		@(posedge clk) plane <= 2'h1;
		u_host.write_reg(8'h0D, 8'h00);
		rd_chk(8'h0D, 8'h04);
		check("modes", {6'h00, shut, rgy, two_bit, 1'b0, last}, 12'h003);
		$display("test config done");
		for (int k = 0; k < 5; k++) begin
			duty(tp[k], t0[k], t1[k]);
		end
		$display("test duty done");
		u_host.write_reg(8'h0D, 8'h80);
		@(posedge clk) pix0 <= 2'h2;
		pix1 <= 2'h2;
		frames(lmi_pkg::PATTERN_ARITH_HI, lmi_pkg::PATTERN_GEOM_HI);
		@(posedge clk) pix0 <= 2'h1;
		pix1 <= 2'h1;
		frames(lmi_pkg::PATTERN_ARITH_LO, lmi_pkg::PATTERN_GEOM_LO);
		@(posedge clk) pix0 <= 2'h3;
		pix1 <= 2'h0;
		frames(lmi_pkg::PATTERN_FULL, lmi_pkg::PATTERN_OFF);
		u_host.write_reg(8'h0D, 8'h00);
		@(posedge clk) pix0 <= 2'h1;
		pix1 <= 2'h2;
		frames(lmi_pkg::PATTERN_FULL, lmi_pkg::PATTERN_OFF);
		$display("test frames done");
		give_verdict();
	end
endmodule

bind lmi_intensity_top lmi_intensity_properties #(.FRAME_PERIODS(FRAME_PERIODS),
	.HAS_COLOUR(HAS_COLOUR), .HAS_PLANE_DEPTH(HAS_PLANE_DEPTH)) u_props (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.CURRENT_PLANE(CURRENT_PLANE), .DIGIT0_GEOMETRIC(DIGIT0_GEOMETRIC),
	.DIGIT1_GEOMETRIC(DIGIT1_GEOMETRIC), .DIGIT0_PIXEL(DIGIT0_PIXEL),
	.DIGIT1_PIXEL(DIGIT1_PIXEL), .COLOUR_RGY(COLOUR_RGY), .PIXEL_TWO_BIT(PIXEL_TWO_BIT),
	.PLANE_LAST(PLANE_LAST), .SHUTDOWN(SHUTDOWN), .PANEL_PWM(PANEL_PWM),
	.DIGIT0_DRIVE(DIGIT0_DRIVE), .DIGIT1_DRIVE(DIGIT1_DRIVE), .FRAME_START(FRAME_START),
	.FRAME_INDEX(FRAME_INDEX));
